//--- instruction_decode_timing.sv
// Purpose: Operation_code_byte fetch, decode and machine-cycle timing for an 8-bit accumulator core
// Assumes: Program memory answers a fetch by the end of its machine cycle
// Notes:   Four clocks per machine cycle; one program byte per fetch cycle, none in the extra ST_EXEC cycles
//
// Behaviour
// RULE1 - Every instruction starts with one 8-bit operation_code_byte byte fetched from program memory
// RULE2 - Zero, one or two operand bytes follow, giving one to three bytes
// RULE3 - Register opcodes pick working register 0..7 from low three operation_code_byte bits
// RULE4 - Direct byte 0..127 reaches data memory, 128..255 special registers
// RULE5 - Indirect opcodes address 0..255 through register zero or one by bit 0
// RULE6 - Relative offset is signed byte added to address after the branch
// RULE7 - Short absolute target keeps upper bits, 11 bits within 2-kilobyte page
// RULE8 - Long call and jump load a full 16-bit target from two bytes
// RULE9 - Short call operation_code_byte holds target bits 10..8 on top, low bits 10001
// RULE10 - Short jump operation_code_byte holds target bits 10..8 on top, low bits 00001
// RULE11 - One-byte accumulator register or indirect operations take 4 clocks
// RULE12 - Two-byte immediate or direct accumulator operations take 8 clocks
// RULE13 - Three-byte read-modify-write immediate to direct takes 12 clocks
// RULE14 - Multiply and divide are one byte and take 20 clocks
// RULE15 - Loading the data pointer immediate takes three bytes and 12 clocks
// RULE16 - Indexed code read and external data transfers take 8 clocks
// RULE17 - Indexed indirect jump is one byte and takes 8 clocks
// RULE18 - Long call is three bytes, 16 clocks, pushes return before loading; PUSH_RETURN and LOAD_TARGET rise in the same clock
// RULE19 - Relative jump and zero or carry jumps take 12 clocks taken or not
// RULE20 - Three-byte bit-test branches take 16 clocks
// RULE21 - Compare-and-jump forms are three bytes and take 16 clocks
// RULE22 - Decrement-and-jump on register is two bytes and 12 clocks
// RULE23 - Execution runs in 4-clock machine cycles, one program byte each; the extra ST_EXEC cycles fetch no byte
// RULE24 - Unlisted opcodes run as one-byte 4-clock no-operations
`timescale 1ns/1ns
module instruction_decode_timing (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  FETCH_DATA,
  input  wire logic [15:0] START_PC,
  input  wire logic        BRANCH_TAKEN,
  output logic      [15:0] FETCH_ADDR,
  output logic             FETCH_REQ,
  output logic             MC_STROBE,
  output logic             INSTR_DONE,
  output logic      [7:0]  OPERATION_CODE_BYTE,
  output logic      [1:0]  INSTR_LENGTH,
  output logic      [4:0]  INSTR_CLOCKS,
  output logic      [2:0]  ADDR_MODE,
  output logic      [2:0]  BANK_WORK_REGISTER,
  output logic             INDIRECT_POINTER_REGISTER,
  output logic             DIRECT_IS_SFR,
  output logic      [15:0] PAGE_TARGET_ADDRESS,
  output logic      [15:0] LONG_TARGET_ADDRESS,
  output logic      [15:0] REL_TARGET_ADDRESS,
  output logic      [15:0] NEXT_PC,
  output logic             PUSH_RETURN,
  output logic             LOAD_TARGET,
  output logic             IS_NOP
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  wire  rst_n = rst_sync_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Machine-cycle phase
  // ----------------------------------------
  // Phase counter gives a one-clock enable at the end of every machine cycle
  logic [1:0] phase_q;
  wire        mc_end = (phase_q == idt_pkg::PHASE_LAST);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1; // RULE23
    end
  end

  // ----------------------------------------
  // Instruction sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_START, ST_OPERATION_CODE_BYTE, ST_OPER1, ST_OPER2, ST_EXEC
  } seq_state_type;

  seq_state_type        state_q;
  seq_state_type        state_d;
  idt_pkg::instr_type   ins_q;
  idt_pkg::decode_type  dec_q;
  idt_pkg::decode_type  dec_now;
  logic [15:0]          pc_q;
  logic [15:0]          pc_d;
  logic [4:0]           mc_left_q;
  logic [4:0]           mc_left_d;
  logic [1:0]           bytes_left_q;

  // Decode straight from the bus so length is known before the next fetch
  idt_operation_code_byte_table u_table (
    .operation_code_byte (FETCH_DATA),
    .info   (dec_now)
  );

  wire [15:0] rel_t;
  wire [15:0] page_t;
  wire [15:0] long_t;
  wire [7:0]  rel_src = (dec_q.length == 2'h3) ? ins_q.operand2 : ins_q.operand1;

  idt_target_calc u_target (
    .operation_code_byte      (ins_q.operation_code_byte),
    .operand1    (ins_q.operand1),
    .operand2    (ins_q.operand2),
    .rel_byte    (rel_src),
    .next_pc     (ins_q.next_pc),
    .rel_target  (rel_t),
    .page_target (page_t),
    .long_target (long_t)
  );

  // Current instruction: a short one ends in its own fetch cycle, before ins_q loads
  wire                 in_operation_code_byte = (state_q == ST_OPERATION_CODE_BYTE);
  wire [7:0]           cur_op    = in_operation_code_byte ? FETCH_DATA : ins_q.operation_code_byte;
  wire [7:0]           cur_b1    = (state_q == ST_OPER1) ? FETCH_DATA : ins_q.operand1;
  idt_pkg::decode_type cur_dec;
  assign cur_dec = in_operation_code_byte ? dec_now : dec_q;

  // Remaining machine cycles once all bytes are in
  wire [4:0] total_mc   = {2'h0, dec_now.clocks[4:2]};
  wire [4:0] extra_mc   = total_mc - {3'h0, dec_now.length};
  wire       fetch_slot = (state_q == ST_OPERATION_CODE_BYTE) || (state_q == ST_OPER1) ||
                          (state_q == ST_OPER2);
  wire       is_call    = (cur_op == idt_pkg::OP_LONG_CALL) ||
                          (cur_op[4:0] == idt_pkg::PAGE_CALL_LOW);
  wire       last_mc    = (state_q == ST_EXEC) && (mc_left_q == 5'h01);
  // Byte and cycle counts still belong to the previous instruction during an operation_code_byte fetch
  wire       op_done    = in_operation_code_byte && (dec_now.length == 2'h1) && (extra_mc == 5'h00);
  wire       opr_done   = (mc_left_q == 5'h00) && ((state_q == ST_OPER2) ||
                          ((state_q == ST_OPER1) && (bytes_left_q == 2'h1)));
  wire       done_now   = mc_end && (last_mc || op_done || opr_done);
  wire [15:0] cur_next  = fetch_slot ? pc_d : ins_q.next_pc;

  always_comb begin
    state_d   = state_q;
    pc_d      = pc_q;
    mc_left_d = mc_left_q;
    case (state_q)
      ST_START:
        state_d = ST_OPERATION_CODE_BYTE;
      ST_OPERATION_CODE_BYTE: begin
        pc_d      = pc_q + 16'h0001; // RULE1
        mc_left_d = extra_mc;
        if (dec_now.length == 2'h1) begin
          state_d = (extra_mc == 5'h00) ? ST_OPERATION_CODE_BYTE : ST_EXEC;
        end else begin
          state_d = ST_OPER1; // RULE2
        end
      end
      ST_OPER1: begin
        pc_d = pc_q + 16'h0001;
        if (bytes_left_q == 2'h2) begin
          state_d = ST_OPER2;
        end else begin
          state_d = (mc_left_q == 5'h00) ? ST_OPERATION_CODE_BYTE : ST_EXEC;
        end
      end
      ST_OPER2: begin
        pc_d    = pc_q + 16'h0001; // RULE2
        state_d = (mc_left_q == 5'h00) ? ST_OPERATION_CODE_BYTE : ST_EXEC;
      end
      ST_EXEC: begin
        mc_left_d = mc_left_q - 5'h01;
        if (mc_left_q == 5'h01) begin
          state_d = ST_OPERATION_CODE_BYTE;
        end
      end
      default:
        state_d = ST_START;
    endcase
  end

  // Control transfer redirects the fetch stream at the end of the instruction
  wire        transfer  = cur_dec.mode == idt_pkg::MODE_LONG ||
                          cur_dec.mode == idt_pkg::MODE_PAGE;
  wire        rel_branch = cur_dec.mode == idt_pkg::MODE_RELATIVE;
  wire [15:0] redirect  = (cur_dec.mode == idt_pkg::MODE_LONG) ? long_t : page_t;
  wire [15:0] pc_final  = (done_now && transfer) ? redirect :
                          (done_now && rel_branch && BRANCH_TAKEN) ? rel_t : pc_d; // RULE6

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_START;
      pc_q         <= 16'h0000;
      mc_left_q    <= 5'h00;
      bytes_left_q <= 2'h0;
      ins_q        <= '0;
      dec_q        <= '0;
    end else if (mc_end) begin
      state_q   <= state_d; // RULE23
      pc_q      <= (state_q == ST_START) ? START_PC : pc_final;
      mc_left_q <= mc_left_d;
      if (state_q == ST_OPERATION_CODE_BYTE) begin
        ins_q.operation_code_byte <= FETCH_DATA; // RULE1
        dec_q        <= dec_now;
        bytes_left_q <= dec_now.length - 2'h1;
      end else if (state_q == ST_OPER1) begin
        ins_q.operand1 <= FETCH_DATA;
      end else if (state_q == ST_OPER2) begin
        ins_q.operand2 <= FETCH_DATA;
      end
      if (fetch_slot) begin
        ins_q.next_pc <= pc_d;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      FETCH_ADDR                <= 16'h0000;
      FETCH_REQ                 <= 1'b0;
      MC_STROBE                 <= 1'b0;
      INSTR_DONE                <= 1'b0;
      OPERATION_CODE_BYTE       <= 8'h00;
      INSTR_LENGTH              <= 2'h0;
      INSTR_CLOCKS              <= 5'h00;
      ADDR_MODE                 <= 3'h0;
      BANK_WORK_REGISTER        <= 3'h0;
      INDIRECT_POINTER_REGISTER <= 1'b0;
      DIRECT_IS_SFR             <= 1'b0;
      PAGE_TARGET_ADDRESS       <= 16'h0000;
      LONG_TARGET_ADDRESS       <= 16'h0000;
      REL_TARGET_ADDRESS        <= 16'h0000;
      NEXT_PC                   <= 16'h0000;
      PUSH_RETURN               <= 1'b0;
      LOAD_TARGET               <= 1'b0;
      IS_NOP                    <= 1'b0;
    end else begin
      MC_STROBE  <= mc_end;
      FETCH_REQ  <= fetch_slot;
      FETCH_ADDR <= pc_q;
      INSTR_DONE <= done_now;
      PUSH_RETURN <= done_now && is_call; // RULE18
      LOAD_TARGET <= done_now && transfer;
      if (done_now) begin
        OPERATION_CODE_BYTE       <= cur_op;
        INSTR_LENGTH              <= cur_dec.length;
        INSTR_CLOCKS              <= cur_dec.clocks;
        ADDR_MODE                 <= cur_dec.mode;
        IS_NOP                    <= cur_dec.is_nop; // RULE24
        BANK_WORK_REGISTER        <= cur_op[2:0]; // RULE3
        INDIRECT_POINTER_REGISTER <= cur_op[0]; // RULE5
        DIRECT_IS_SFR             <= cur_b1 >= idt_pkg::DIRECT_SFR_MIN; // RULE4
        PAGE_TARGET_ADDRESS       <= page_t; // RULE7
        LONG_TARGET_ADDRESS       <= long_t; // RULE8
        REL_TARGET_ADDRESS        <= rel_t; // RULE6
        NEXT_PC                   <= cur_next;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Parks at its reset value so the first instruction after reset is not timed
  logic [4:0] clk_cnt_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_cnt_q <= 5'h1F;
    end else if (INSTR_DONE) begin
      clk_cnt_q <= 5'h01;
    end else if (clk_cnt_q != 5'h1F) begin
      clk_cnt_q <= clk_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  instr_clocks_match_a: assert property ( // RULE11
    INSTR_DONE && clk_cnt_q != 5'h1F |-> clk_cnt_q == INSTR_CLOCKS)
    else $error("instruction clock count mismatch");
  mc_period_a: assert property (MC_STROBE |=> !MC_STROBE [*3] ##1 MC_STROBE) // RULE23
    else $error("machine cycle is not four clocks");
  done_on_mc_a: assert property (INSTR_DONE |-> MC_STROBE) // RULE23
    else $error("instruction end off machine-cycle boundary");
  length_range_a: assert property (INSTR_DONE |-> INSTR_LENGTH != 2'h0) // RULE2
    else $error("instruction length out of range");
  mul_clocks_a: assert property ( // RULE14
    INSTR_DONE && (OPERATION_CODE_BYTE == idt_pkg::OP_MUL ||
    OPERATION_CODE_BYTE == idt_pkg::OP_DIV) |-> INSTR_CLOCKS == idt_pkg::CLK20
    && INSTR_LENGTH == 2'h1)
    else $error("multiply or divide timing wrong");
  load_dp_a: assert property ( // RULE15
    INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_LOAD_DP |->
    INSTR_CLOCKS == idt_pkg::CLK12 && INSTR_LENGTH == 2'h3)
    else $error("data pointer load timing wrong");
  long_call_a: assert property ( // RULE18
    INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_LONG_CALL |->
    PUSH_RETURN && LOAD_TARGET && INSTR_CLOCKS == idt_pkg::CLK16)
    else $error("long call handling wrong");
  rel_jump_a: assert property ( // RULE19
    INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_REL_JUMP |->
    INSTR_CLOCKS == idt_pkg::CLK12 && INSTR_LENGTH == 2'h2)
    else $error("relative jump timing wrong");
  indexed_jump_a: assert property ( // RULE17
    INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_JMP_INDEXED |->
    INSTR_CLOCKS == idt_pkg::CLK8 && INSTR_LENGTH == 2'h1)
    else $error("indexed jump timing wrong");
  page_target_a: assert property ( // RULE7
    INSTR_DONE && ADDR_MODE == idt_pkg::MODE_PAGE |->
    PAGE_TARGET_ADDRESS[15:11] == NEXT_PC[15:11])
    else $error("page target left its page");

  code_read_a: assert property ( // RULE16
    INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_CODE_READ |->
    INSTR_CLOCKS == idt_pkg::CLK8 && INSTR_LENGTH == 2'h1)
    else $error("code read timing wrong");
  nop_timing_a: assert property ( // RULE24
    INSTR_DONE && IS_NOP |->
    INSTR_CLOCKS == idt_pkg::CLK4 && INSTR_LENGTH == 2'h1)
    else $error("no-operation timing wrong");
  load_on_done_a: assert property (LOAD_TARGET |-> INSTR_DONE && // RULE8
    (ADDR_MODE == idt_pkg::MODE_PAGE || ADDR_MODE == idt_pkg::MODE_LONG))
    else $error("target load outside an absolute transfer");
  done_pulse_a: assert property (INSTR_DONE |=> !INSTR_DONE) // RULE23
    else $error("instruction end longer than one clock");

  mul_seen_c: cover property (INSTR_DONE && OPERATION_CODE_BYTE == idt_pkg::OP_MUL);
  long_call_c: cover property (INSTR_DONE && PUSH_RETURN);
  nop_seen_c: cover property (INSTR_DONE && IS_NOP);
  rel_branch_c: cover property (INSTR_DONE && ADDR_MODE == idt_pkg::MODE_RELATIVE);
  sfr_direct_c: cover property (INSTR_DONE && DIRECT_IS_SFR);

endmodule

//--- idt_pkg.sv
// Purpose: Shared constants and types for the operation_code_byte decoder and timing controller
// Assumes: One 250 MHz clock, four clocks per machine cycle
// Notes:   Named encodings and figures shared by the decoder live here; the table also lists opcodes as literals
package idt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          CLOCKS_PER_MC   = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;
  localparam logic [4:0]  CLK4            = 5'h04;
  localparam logic [4:0]  CLK8            = 5'h08;
  localparam logic [4:0]  CLK12           = 5'h0C;
  localparam logic [4:0]  CLK16           = 5'h10;
  localparam logic [4:0]  CLK20           = 5'h14;

  // ----------------------------------------
  // Operation_code_byte encodings
  // ----------------------------------------
  localparam logic [4:0]  PAGE_CALL_LOW   = 5'h11;
  localparam logic [4:0]  PAGE_JUMP_LOW   = 5'h01;
  localparam logic [7:0]  OP_LONG_CALL    = 8'h12;
  localparam logic [7:0]  OP_LONG_JUMP    = 8'h02;
  localparam logic [7:0]  OP_REL_JUMP     = 8'h80;
  localparam logic [7:0]  OP_JMP_INDEXED  = 8'h73;
  localparam logic [7:0]  OP_MUL          = 8'hA4;
  localparam logic [7:0]  OP_DIV          = 8'h84;
  localparam logic [7:0]  OP_LOAD_DP      = 8'h90;
  localparam logic [7:0]  OP_CODE_READ    = 8'h93;
  localparam logic [7:0]  DIRECT_SFR_MIN  = 8'h80;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_NONE, MODE_REG, MODE_INDIRECT, MODE_DIRECT, MODE_IMMEDIATE,
    MODE_RELATIVE, MODE_PAGE, MODE_LONG
  } addr_mode_type;

  typedef struct packed {
    logic [1:0]    length;
    logic [4:0]    clocks;
    addr_mode_type mode;
    logic          is_nop;
  } decode_type;

  typedef struct packed {
    logic [7:0]  operation_code_byte;
    logic [7:0]  operand1;
    logic [7:0]  operand2;
    logic [15:0] next_pc;
  } instr_type;

endpackage

//--- idt_operation_code_byte_table.sv
// Purpose: Combinational operation_code_byte to length, clocks and mode lookup
// Assumes: Operation_code_byte is stable while read
// Notes:   Unlisted opcodes fall to a one-byte 4-clock no-operation
`timescale 1ns/1ns
module idt_operation_code_byte_table (
  input  wire logic [7:0]         operation_code_byte,
  output idt_pkg::decode_type     info
);

  wire [2:0] low3 = operation_code_byte[2:0];
  wire [3:0] hi   = operation_code_byte[7:4];
  wire       is_reg = operation_code_byte[3];
  wire       is_ind = (operation_code_byte[3:1] == 3'h3);

  always_comb begin
    info.length = 2'h1;
    info.clocks = idt_pkg::CLK4;
    info.mode   = idt_pkg::MODE_NONE;
    info.is_nop = 1'b0;
    if (operation_code_byte[4:0] == idt_pkg::PAGE_CALL_LOW) begin
      info = '{2'h2, idt_pkg::CLK12, idt_pkg::MODE_PAGE, 1'b0}; // RULE9 RULE7
    end else if (operation_code_byte[4:0] == idt_pkg::PAGE_JUMP_LOW) begin
      info = '{2'h2, idt_pkg::CLK12, idt_pkg::MODE_PAGE, 1'b0}; // RULE10 RULE7
    end else begin
      case (operation_code_byte)
        8'h00, 8'h04, 8'h14, 8'hD4, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13,
        8'hC4, 8'hC3, 8'hD3, 8'hB3:
          info.clocks = idt_pkg::CLK4;
        8'h12, 8'h02: begin
          info = '{2'h3, idt_pkg::CLK16, idt_pkg::MODE_LONG, 1'b0}; // RULE8 RULE18
        end
        8'h80, 8'h60, 8'h70, 8'h40, 8'h50: begin
          info = '{2'h2, idt_pkg::CLK12, idt_pkg::MODE_RELATIVE, 1'b0}; // RULE19 RULE6
        end
        8'h10, 8'h20, 8'h30, 8'hB4, 8'hB5, 8'hD5: begin
          info = '{2'h3, idt_pkg::CLK16, idt_pkg::MODE_RELATIVE, 1'b0}; // RULE20 RULE21
        end
        8'hA4, 8'h84:
          info.clocks = idt_pkg::CLK20; // RULE14
        8'h90: begin
          info = '{2'h3, idt_pkg::CLK12, idt_pkg::MODE_IMMEDIATE, 1'b0}; // RULE15
        end
        8'h93, 8'h83, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3, 8'h73, 8'h22,
        8'h32, 8'hA3:
          info.clocks = idt_pkg::CLK8; // RULE16 RULE17
        8'h53, 8'h43, 8'h63, 8'h75, 8'h85: begin
          info = '{2'h3, idt_pkg::CLK12, idt_pkg::MODE_DIRECT, 1'b0}; // RULE13
        end
        8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64, 8'h74: begin
          info = '{2'h2, idt_pkg::CLK8, idt_pkg::MODE_IMMEDIATE, 1'b0}; // RULE12
        end
        8'h25, 8'h35, 8'h95, 8'h05, 8'h15, 8'h55, 8'h52, 8'h45, 8'h42, 8'h65,
        8'h62, 8'hE5, 8'hF5, 8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82,
        8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h86, 8'h87, 8'hA6, 8'hA7: begin
          info = '{2'h2, idt_pkg::CLK8, idt_pkg::MODE_DIRECT, 1'b0};
        end
        8'h76, 8'h77: begin
          info = '{2'h2, idt_pkg::CLK8, idt_pkg::MODE_IMMEDIATE, 1'b0};
        end
        8'hB6, 8'hB7: begin
          info = '{2'h3, idt_pkg::CLK16, idt_pkg::MODE_RELATIVE, 1'b0}; // RULE21
        end
        default: begin
          if (is_reg) begin
            case (hi)
              4'h2, 4'h3, 4'h9, 4'h0, 4'h1, 4'h5, 4'h4, 4'h6, 4'hE, 4'hF, 4'hC:
                info.mode = idt_pkg::MODE_REG; // RULE11 RULE3
              4'hA, 4'h8, 4'h7: begin
                info = '{2'h2, idt_pkg::CLK8, idt_pkg::MODE_REG, 1'b0};
              end
              4'hB: begin
                info = '{2'h3, idt_pkg::CLK16, idt_pkg::MODE_RELATIVE, 1'b0}; // RULE21
              end
              4'hD: begin
                info = '{2'h2, idt_pkg::CLK12, idt_pkg::MODE_RELATIVE, 1'b0}; // RULE22
              end
              default:
                info.is_nop = 1'b1;
            endcase
          end else if (is_ind && hi != 4'hA && hi != 4'h8 && hi != 4'hB) begin
            info.mode = idt_pkg::MODE_INDIRECT; // RULE11 RULE5
          end else if (low3 == 3'h7 && hi == 4'hD) begin
            info.mode = idt_pkg::MODE_INDIRECT;
          end else begin
            info.is_nop = 1'b1; // RULE24
          end
        end
      endcase
    end
  end

endmodule

//--- idt_target_calc.sv
// Purpose: Relative, page and long branch target address formation
// Assumes: next_pc is the address of the first byte after the instruction
// Notes:   Pure combinational; the top registers the results
`timescale 1ns/1ns
module idt_target_calc (
  input  wire logic [7:0]  operation_code_byte,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [7:0]  rel_byte,
  input  wire logic [15:0] next_pc,
  output logic      [15:0] rel_target,
  output logic      [15:0] page_target,
  output logic      [15:0] long_target
);

  wire [15:0] rel_ext = {{8{rel_byte[7]}}, rel_byte};

  assign rel_target  = next_pc + rel_ext; // RULE6
  assign page_target = {next_pc[15:11], operation_code_byte[7:5], operand1}; // RULE7
  assign long_target = {operand1, operand2}; // RULE8

endmodule

//--- prog_mem_model.sv
// Purpose: Program memory model answering the fetch port of the decoder
// Assumes: One byte per machine cycle, presented before the sampling clock
// Notes:   Idle data toggles so a stale byte never passes for an answer
`timescale 1ns/1ns
module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  output logic      [7:0]  fetch_data
);
  logic [7:0] mem [0:65535];

  initial begin
    fetch_data = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  // --------------------------------
  // Fetch answer
  // --------------------------------
  // Updated every cycle so the byte follows the address within its machine cycle
  always @(negedge clk) begin
    fetch_data <= fetch_req ? mem[fetch_addr] : ~fetch_data;
  end
endmodule

//--- instruction_decode_timing_test.sv
// Purpose: Self-checking bench for the operation_code_byte decoder and timing controller
// Assumes: Absolute and 80 targets sit at the fall-through address; other relative ones only when zero_rel is set
// Notes:   Linear flow keeps expectations free of redirect latency
`timescale 1ns/1ns
module instruction_decode_timing_test;
  // --------------------------------
  // Signals
  // --------------------------------
  typedef struct {
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [1:0]  len;
    logic [4:0]  clks;
    logic [15:0] nxt;
    logic [15:0] tgt;
    logic [1:0]  kind;
  } exp_type;
  logic        CLK, RST_B, BRANCH_TAKEN, FETCH_REQ, MC_STROBE, INSTR_DONE;
  logic        INDIRECT_POINTER_REGISTER, DIRECT_IS_SFR, PUSH_RETURN, LOAD_TARGET, IS_NOP;
  logic [7:0]  FETCH_DATA, OPERATION_CODE_BYTE;
  logic [15:0] START_PC, FETCH_ADDR, NEXT_PC;
  logic [15:0] PAGE_TARGET_ADDRESS, LONG_TARGET_ADDRESS, REL_TARGET_ADDRESS;
  logic [1:0]  INSTR_LENGTH;
  logic [4:0]  INSTR_CLOCKS;
  logic [2:0]  ADDR_MODE, BANK_WORK_REGISTER;
  logic [15:0] lfsr = 16'h0005;
  exp_type     q[$];
  exp_type     m;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          gap = 0;
  logic        seen = 1'b0;
  logic        rand_bt;
  // Entry: operation_code_byte, length in bits 6:5, clocks in bits 4:0
  localparam logic [15:0] PROG [27] = '{
    16'h014C, 16'h114C, 16'h0024, 16'h2824, 16'h2F24, 16'h2624, 16'h2724, 16'h2548,
    16'h2548, 16'h2448, 16'h536C, 16'hA434, 16'h8434, 16'h906C, 16'h9328, 16'hE028,
    16'h7328, 16'h1270, 16'h0270, 16'h804C, 16'h604C, 16'h404C, 16'h1070, 16'hB470,
    16'hD84C, 16'hDF4C, 16'hA524};

  instruction_decode_timing u_dut (.CLK(CLK), .RST_B(RST_B), .FETCH_DATA(FETCH_DATA),
    .START_PC(START_PC), .BRANCH_TAKEN(BRANCH_TAKEN), .FETCH_ADDR(FETCH_ADDR),
    .FETCH_REQ(FETCH_REQ), .MC_STROBE(MC_STROBE), .INSTR_DONE(INSTR_DONE),
    .OPERATION_CODE_BYTE(OPERATION_CODE_BYTE), .INSTR_LENGTH(INSTR_LENGTH),
    .INSTR_CLOCKS(INSTR_CLOCKS), .ADDR_MODE(ADDR_MODE),
    .BANK_WORK_REGISTER(BANK_WORK_REGISTER),
    .INDIRECT_POINTER_REGISTER(INDIRECT_POINTER_REGISTER), .DIRECT_IS_SFR(DIRECT_IS_SFR),
    .PAGE_TARGET_ADDRESS(PAGE_TARGET_ADDRESS), .LONG_TARGET_ADDRESS(LONG_TARGET_ADDRESS),
    .REL_TARGET_ADDRESS(REL_TARGET_ADDRESS), .NEXT_PC(NEXT_PC), .PUSH_RETURN(PUSH_RETURN),
    .LOAD_TARGET(LOAD_TARGET), .IS_NOP(IS_NOP));

  prog_mem_model u_mem (.clk(CLK), .fetch_req(FETCH_REQ), .fetch_addr(FETCH_ADDR),
    .fetch_data(FETCH_DATA));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  function logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Absolute and 80 targets equal the fall-through address, other relative ones only with zero_rel, so then the flow is linear taken or not
  task automatic build(input logic [15:0] start, input logic zero_rel);
    logic [15:0] a;
    logic [7:0]  b2;
    logic [7:0]  rl;
    exp_type     e;
    a = start;
    for (int i = 0; i < 27; i++) begin
      e.op   = PROG[i][15:8];
      e.len  = PROG[i][6:5];
      e.clks = PROG[i][4:0];
      e.nxt  = a + 16'(e.len);
      e.b1   = rnd();
      b2     = rnd();
      e.kind = 2'h0;
      e.tgt  = e.nxt;
      if (e.op == 8'h25) e.b1 = (i == 7) ? 8'h7F : 8'h80;
      if (e.op[4:0] == 5'h01 || e.op[4:0] == 5'h11) begin
        e.kind = 2'h1;
        e.op   = {e.nxt[10:8], e.op[4:0]};
        e.b1   = e.nxt[7:0];
      end else if (e.op == 8'h02 || e.op == 8'h12) begin
        e.kind = 2'h2;
        e.b1   = e.nxt[15:8];
        b2     = e.nxt[7:0];
      end else if (e.op inside {8'h80, 8'h60, 8'h40, 8'h10, 8'hB4, 8'hD8, 8'hDF}) begin
        e.kind = 2'h3;
        if (zero_rel || e.op == 8'h80) begin
          e.b1 = 8'h00;
          b2   = 8'h00;
        end
        rl    = (e.len == 2'h3) ? b2 : e.b1;
        e.tgt = e.nxt + {{8{rl[7]}}, rl};
      end
      u_mem.mem[a] = e.op;
      if (e.len > 2'h1) u_mem.mem[a + 16'h0001] = e.b1;
      if (e.len > 2'h2) u_mem.mem[a + 16'h0002] = b2;
      q.push_back(e);
      a = e.nxt;
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 3000 && q.size() > 0; k++) @(negedge CLK);
    if (q.size() > 0) begin
      error_cnt++;
      $display("Error drain expected 0 seen %0d", q.size());
      stop_test();
    end
  endtask

  // --------------------------------
  // Result watcher
  // --------------------------------
  always @(negedge CLK) begin
    gap = gap + 1;
    if (RST_B !== 1'b1) begin
      seen = 1'b0;
    end else if (INSTR_DONE === 1'b1 && q.size() > 0) begin
      m = q.pop_front();
      chk("operation_code_byte", m.op, OPERATION_CODE_BYTE);
      chk("length", m.len, INSTR_LENGTH);
      chk("clocks", m.clks, INSTR_CLOCKS);
      if (seen) chk("spacing", m.clks, 16'(gap));
      chk("next_pc", m.nxt, NEXT_PC);
      chk("nop", m.op == 8'hA5, IS_NOP);
      chk("push", m.op == 8'h12 || m.op[4:0] == 5'h11, PUSH_RETURN);
      chk("load", m.kind == 2'h1 || m.kind == 2'h2, LOAD_TARGET);
      if (m.kind == 2'h1) chk("page", m.tgt, PAGE_TARGET_ADDRESS);
      if (m.kind == 2'h2) chk("long", m.tgt, LONG_TARGET_ADDRESS);
      if (m.kind == 2'h3) chk("rel", m.tgt, REL_TARGET_ADDRESS);
      if (m.op inside {8'h28, 8'h2F, 8'hD8, 8'hDF}) chk("bank", m.op[2:0], BANK_WORK_REGISTER);
      if (m.op inside {8'h26, 8'h27}) chk("pointer", m.op[0], INDIRECT_POINTER_REGISTER);
      if (m.op == 8'h25) chk("sfr", m.b1[7], DIRECT_IS_SFR);
      seen = 1'b1;
      gap  = 0;
    end
  end

  always @(negedge CLK) begin
    if (rand_bt) BRANCH_TAKEN <= ^rnd();
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    RST_B        = 1'b0;
    START_PC     = 16'h07FE;
    BRANCH_TAKEN = 1'b0;
    rand_bt      = 1'b0;
    // Page jump at the page end: its target lies in the next page
    // Load after time zero so the memory model's own clearing cannot wipe it
    @(negedge CLK);
    build(16'h07FE, 1'b0);
    repeat (2) @(negedge CLK);
    RST_B = 1'b1;
    drain();
    RST_B    = 1'b0;
    START_PC = 16'h3A00;
    build(16'h3A00, 1'b1);
    rand_bt = 1'b1;
    repeat (3) @(negedge CLK);
    RST_B = 1'b1;
    drain();
    stop_test();
  end
endmodule
